// file: line_status_pkg.sv
// shared constants for the per-channel line status register bank
package line_status_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int unsigned     num_channels      = 4;
  localparam logic [11:0]     status_offset_ch0 = 12'h104;
  localparam logic [11:0]     channel_stride    = 12'h080;
  localparam logic [31:0]     status_reset      = 32'h0000_0000;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned     cts_bit           = 24;
  localparam int unsigned     cd_bit            = 21;
  localparam int unsigned     dpll_bit          = 19;
  localparam int unsigned     dsr_bit           = 0;
  localparam int unsigned     dsr_channel       = 3;
  // ****************************************************************
  // line code selection
  // ****************************************************************
  localparam logic [2:0]      code_fm0          = 3'h4;
  localparam logic [2:0]      code_fm1          = 3'h5;
  localparam logic [2:0]      code_manchester   = 3'h6;
endpackage : line_status_pkg

// file: serial_channel_status.sv
// read-only line status words for four serial channels
`timescale 1ns/1ps
module serial_channel_status
  import line_status_pkg::*;
#(
  // the address map and the set-ready channel assume the default count
  parameter int unsigned channels = num_channels
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic [11:0]          read_addr,
  input  wire logic                 read_strobe,
  output logic      [31:0]          read_data,
  output logic                      read_hit,
  input  wire logic [channels-1:0]  cts_n,
  input  wire logic [channels-1:0]  carrier_detect,
  input  wire logic                 last_channel_set_ready,
  input  wire logic [channels-1:0]  tx_clock_enable,
  input  wire logic [channels-1:0]  rx_clock_enable,
  input  wire logic [channels-1:0]  dpll_locked,
  input  wire logic [channels-1:0]  rx_clock_from_dpll,
  input  wire logic [channels-1:0]  tx_clock_from_dpll,
  input  wire logic [3*channels-1:0] line_code_select,
  input  wire logic [channels-1:0]  cts_change_enable,
  input  wire logic [channels-1:0]  cd_change_enable,
  output logic      [channels-1:0]  cts_change_event,
  output logic      [channels-1:0]  cd_change_event,
  output logic      [channels-1:0]  rx_accept_enable,
  output logic      [channels-1:0]  tx_halt,
  output logic      [channels-1:0]  dpll_resync_start
);

  // ****************************************************************
  // decoding helpers
  // ****************************************************************
  function automatic logic code_uses_dpll(input logic [2:0] code);
    code_uses_dpll = (code == code_fm0) || (code == code_fm1) ||
                     (code == code_manchester);
  endfunction : code_uses_dpll

  // channel words sit one stride apart, starting at the first channel's word
  function automatic logic [11:0] channel_addr(input int unsigned ch);
    channel_addr = status_offset_ch0 + 12'(ch) * channel_stride;
  endfunction : channel_addr

  // ****************************************************************
  // synchronizers (all on the one clock)
  // ****************************************************************
  logic [channels-1:0] cts_meta;
  logic [channels-1:0] cts_sync;
  logic [channels-1:0] cd_meta;
  logic [channels-1:0] cd_sync;
  logic                dsr_meta;
  logic                dsr_sync;
  logic [channels-1:0] next_cts_meta;
  logic [channels-1:0] next_cts_sync;
  logic [channels-1:0] next_cd_meta;
  logic [channels-1:0] next_cd_sync;
  logic                next_dsr_meta;
  logic                next_dsr_sync;

  // the cts, cd and dsr bits show synchronized levels only, so a read never
  // catches a pin halfway through a transition
  always_comb begin
    // two stages, first stage read only by the second
    next_cts_meta = ~cts_n;
    next_cts_sync = cts_meta;
    next_cd_meta  = carrier_detect;
    next_cd_sync  = cd_meta;
    next_dsr_meta = last_channel_set_ready;
    next_dsr_sync = dsr_meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cts_meta <= '0;
      cts_sync <= '0;
      cd_meta  <= '0;
      cd_sync  <= '0;
      dsr_meta <= 1'b0;
      dsr_sync <= 1'b0;
    end else begin
      cts_meta <= next_cts_meta;
      cts_sync <= next_cts_sync;
      cd_meta  <= next_cd_meta;
      cd_sync  <= next_cd_sync;
      dsr_meta <= next_dsr_meta;
      dsr_sync <= next_dsr_sync;
    end
  end

  // ****************************************************************
  // per-channel sampled state
  // ****************************************************************
  logic [channels-1:0] cts_state;
  logic [channels-1:0] cd_state;
  logic [channels-1:0] dpll_unlocked_flag;
  logic [channels-1:0] dpll_valid;
  logic [channels-1:0] next_cts_state;
  logic [channels-1:0] next_cd_state;
  logic [channels-1:0] next_dpll_unlocked_flag;
  logic [channels-1:0] next_cts_change_event;
  logic [channels-1:0] next_cd_change_event;
  logic [channels-1:0] next_dpll_resync_start;

  // one copy of the sampling logic per channel; channels share nothing
  genvar g;
  generate
    for (g = 0; g < channels; g++) begin : g_chan
      // dpll recovery and code qualify
      // outside the qualifying codes the flag is forced low, so a stale
      // unlock left over from another mode never gates the receiver
      assign dpll_valid[g] = rx_clock_from_dpll[g] &
                             code_uses_dpll(line_code_select[3*g +: 3]);
      always_comb begin
        // a stopped line clock freezes the last sampled level; software
        // must not take it for the live pin state
        // hold value when no transmit clock runs
        next_cts_state[g] = tx_clock_enable[g] ? cts_sync[g] : cts_state[g];
        // hold value when no receive clock runs
        next_cd_state[g]  = rx_clock_enable[g] ? cd_sync[g] : cd_state[g];
        // trade-off: events are bare pulses with no sticky status here,
        // so whoever raises the interrupt must latch them
        // one-cycle pulse per sampled level change
        next_cts_change_event[g] = cts_change_enable[g] &
                                   (next_cts_state[g] != cts_state[g]);
        next_cd_change_event[g]  = cd_change_enable[g] &
                                   (next_cd_state[g] != cd_state[g]);
        next_dpll_unlocked_flag[g] = dpll_valid[g] & ~dpll_locked[g];
        // kick resync on the rising edge of the unlocked flag
        next_dpll_resync_start[g] = next_dpll_unlocked_flag[g] &
                                    ~dpll_unlocked_flag[g];
      end
      assign rx_accept_enable[g] = ~dpll_unlocked_flag[g];
      // transmitter halted when its clock comes from the dpll
      assign tx_halt[g] = dpll_unlocked_flag[g] & tx_clock_from_dpll[g];
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) begin
      cts_state          <= '0;
      cd_state           <= '0;
      dpll_unlocked_flag <= '0;
      cts_change_event   <= '0;
      cd_change_event    <= '0;
      dpll_resync_start  <= '0;
    end else begin
      cts_state          <= next_cts_state;
      cd_state           <= next_cd_state;
      dpll_unlocked_flag <= next_dpll_unlocked_flag;
      cts_change_event   <= next_cts_change_event;
      cd_change_event    <= next_cd_change_event;
      dpll_resync_start  <= next_dpll_resync_start;
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  logic [31:0] next_read_data;
  logic        next_read_hit;
  logic [31:0] channel_line_status;

  always_comb begin
    next_read_data = status_reset;
    next_read_hit  = 1'b0;
    channel_line_status = status_reset;
    for (int unsigned ch = 0; ch < channels; ch++) begin
      channel_line_status = status_reset;
      // active low input reported as one
      channel_line_status[cts_bit]  = cts_state[ch];
      channel_line_status[cd_bit]   = cd_state[ch];
      // lock loss shown in the word
      channel_line_status[dpll_bit] = dpll_unlocked_flag[ch];
      // limitation: the data-set-ready pin is not gated by any line clock
      // data-set-ready only in the last channel
      if (ch == dsr_channel) begin
        channel_line_status[dsr_bit] = dsr_sync;
      end
      if (read_strobe && (read_addr == channel_addr(ch))) begin
        next_read_data = channel_line_status;
        next_read_hit  = 1'b1;
      end
    end
  end

  // the answer stands for one cycle only; the host takes read_data
  // in the cycle in which read_hit is high
  always_ff @(posedge clock) begin
    if (rst) begin
      read_data <= status_reset;
      read_hit  <= 1'b0;
    end else begin
      read_data <= next_read_data;
      read_hit  <= next_read_hit;
    end
  end

endmodule : serial_channel_status

// file: remote_line.sv
// modem equipment model driving the modem inputs and line clocks
`timescale 1ns/1ps
module remote_line (
  input  wire logic       clock,
  input  wire logic       run,
  input  wire logic [3:0] cts_on,
  input  wire logic [3:0] cd_on,
  input  wire logic       dsr_on,
  output logic      [3:0] cts_n,
  output logic      [3:0] carrier_detect,
  output logic            last_channel_set_ready,
  output logic      [3:0] tick
);
  initial tick = 4'h0;
  // line clocks stand still while the link is idle
  always @(posedge clock) begin
    cts_n                  <= ~cts_on;
    carrier_detect         <= cd_on;
    last_channel_set_ready <= dsr_on;
    tick                   <= run ? ~tick : 4'h0;
  end
endmodule : remote_line

// file: line_status_asserts.sv
// checker for the line status register bank
`timescale 1ns/1ps
module line_status_asserts (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [11:0] read_addr,
  input wire logic        read_strobe,
  input wire logic [31:0] read_data,
  input wire logic        read_hit,
  input wire logic [3:0]  dpll_locked,
  input wire logic [3:0]  tx_clock_from_dpll,
  input wire logic [3:0]  rx_accept_enable,
  input wire logic [3:0]  tx_halt,
  input wire logic [3:0]  dpll_resync_start
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire sel = read_addr inside {12'h104, 12'h184, 12'h204, 12'h284};
  property p_hit; read_strobe && sel |=> read_hit; endproperty
  a_hit: assert property (p_hit) else $error("status read not answered");
  property p_miss; !(read_strobe && sel) |=> !read_hit && read_data == 32'h0; endproperty
  a_miss: assert property (p_miss) else $error("answer without status read");
  property p_rsvd; read_hit |-> (read_data & 32'hfed7_fffe) == 32'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("unassigned bit set");
  property p_dsr; read_strobe && read_addr != 12'h284 |=> !read_data[0]; endproperty
  a_dsr: assert property (p_dsr) else $error("set ready bit outside channel 3");
  property p_lock; dpll_locked[0] |=> rx_accept_enable[0]; endproperty
  a_lock: assert property (p_lock) else $error("receive refused while locked");
  property p_halt; tx_halt[0] == (tx_clock_from_dpll[0] && !rx_accept_enable[0]); endproperty
  a_halt: assert property (p_halt) else $error("halt without dpll clock");
  property p_resync; dpll_resync_start[0] |-> !rx_accept_enable[0] ##1 !dpll_resync_start[0];
  endproperty
  a_resync: assert property (p_resync) else $error("resync pulse wrong");
  property p_quiet; $past(dpll_locked[0]) |-> !dpll_resync_start[0]; endproperty
  a_quiet: assert property (p_quiet) else $error("resync while locked");
endmodule : line_status_asserts
bind serial_channel_status line_status_asserts i_chk (.clock, .rst, .read_addr, .read_strobe,
  .read_data, .read_hit, .dpll_locked, .tx_clock_from_dpll, .rx_accept_enable, .tx_halt,
  .dpll_resync_start);

// file: tb_top.sv
// self-checking bench for the line status register bank
`timescale 1ns/1ps
module tb_top;
  import line_status_pkg::*;
  typedef struct packed {logic [3:0] cts; logic [3:0] cd; logic dsr;
    logic [11:0] addr; logic hit; logic [31:0] word;} row_t;
  row_t        rows [5] = '{'{4'h1, 4'h0, 1'b0, 12'h104, 1'b1, 32'h0100_0000},
    '{4'h0, 4'h2, 1'b0, 12'h184, 1'b1, 32'h0020_0000},
    '{4'h4, 4'h0, 1'b1, 12'h204, 1'b1, 32'h0100_0000},
    '{4'hf, 4'h8, 1'b1, 12'h284, 1'b1, 32'h0120_0001},
    '{4'hf, 4'h8, 1'b1, 12'h304, 1'b0, 32'h0000_0000}};
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        read_strobe = 1'b0;
  logic        run = 1'b0;
  logic        dsr_on = 1'b0;
  logic        read_hit, last_channel_set_ready, h, f;
  logic [11:0] read_addr = 12'h000;
  logic [11:0] line_code_select = 12'h000;
  logic [3:0]  cts_on = 4'h0;
  logic [3:0]  cd_on = 4'h0;
  logic [3:0]  dpll_locked = 4'hf;
  logic [3:0]  from_dpll = 4'h0;
  logic [3:0]  tx_dpll = 4'h0;
  logic [3:0]  change_en = 4'hf;
  logic [3:0]  cts_event, cd_event;
  logic        count_on = 1'b0;
  int          cts_events = 0;
  int          cd_events = 0;
  logic [3:0]  cts_n, carrier_detect, tick, rx_accept_enable, tx_halt;
  logic [31:0] read_data, d;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  always #50 clock = ~clock;
  remote_line i_line (.clock, .run, .cts_on, .cd_on, .dsr_on, .cts_n, .carrier_detect,
    .last_channel_set_ready, .tick);
  serial_channel_status i_dut (.clock, .rst, .read_addr, .read_strobe, .read_data, .read_hit,
    .cts_n, .carrier_detect, .last_channel_set_ready, .tx_clock_enable(tick),
    .rx_clock_enable(tick), .dpll_locked, .rx_clock_from_dpll(from_dpll),
    .tx_clock_from_dpll(tx_dpll), .line_code_select, .cts_change_enable(change_en),
    .cd_change_enable(change_en), .cts_change_event(cts_event), .cd_change_event(cd_event),
    .rx_accept_enable,
    .tx_halt, .dpll_resync_start());
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t word %h not %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_flag(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t flags %h not %h", $time, got, exp);
    end
  endtask : cmp_flag
  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    read_strobe <= 1'b1;
    read_addr <= a;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1;
    d = read_data;
    h = read_hit;
    @(posedge clock);
  endtask : rd
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // the run is about 126 cycles; the ceiling leaves wide margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end
  // change events are one-cycle pulses, so they are counted as they pass
  always @(posedge clock) begin
    if (count_on) begin
      cts_events += $countones(cts_event);
      cd_events += $countones(cd_event);
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    run <= 1'b1;
    @(posedge clock);
    cmp_flag(rx_accept_enable, 4'hf);
    foreach (rows[i]) begin
      cts_on <= rows[i].cts;
      cd_on <= rows[i].cd;
      dsr_on <= rows[i].dsr;
      repeat (8) @(posedge clock);
      rd(rows[i].addr);
      cmp_word(d, rows[i].word);
      cmp_flag({3'h0, h}, {3'h0, rows[i].hit});
      $display("row %0d done", i);
    end
    // with line clocks stopped the sampled levels must hold
    run <= 1'b0;
    cts_on <= 4'h0;
    cd_on <= 4'h0;
    repeat (8) @(posedge clock);
    rd(12'h284);
    cmp_word(d, 32'h0120_0001);
    $display("stopped clock test done");
    run <= 1'b1;
    change_en <= 4'h9;
    count_on <= 1'b1;
    from_dpll <= 4'h1;
    tx_dpll <= 4'h1;
    dpll_locked <= 4'he;
    for (int c = 0; c < 8; c++) begin
      line_code_select <= {9'h000, 3'(c)};
      repeat (3) @(posedge clock);
      f = 3'(c) inside {code_fm0, code_fm1, code_manchester};
      cmp_flag(rx_accept_enable, {3'h7, !f});
      cmp_flag(tx_halt, {3'h0, f});
      rd(12'h104);
      cmp_word(d & 32'h0008_0000, {12'h000, f, 19'h00000});
    end
    // receiver gated, but a transmit clock from elsewhere keeps running
    line_code_select <= {9'h000, code_fm0};
    tx_dpll <= 4'h0;
    repeat (3) @(posedge clock);
    cmp_flag(tx_halt, 4'h0);
    cmp_flag(rx_accept_enable, 4'he);
    dpll_locked <= 4'hf;
    repeat (3) @(posedge clock);
    cmp_flag(rx_accept_enable, 4'hf);
    $display("dpll test done");
    cmp_word(32'(cts_events), 32'h2);
    cmp_word(32'(cd_events), 32'h1);
    $display("change event test done");
    end_of_test();
  end
endmodule : tb_top
